// *** core/modulo_bitrev_address_gen.v ***
/*
 * Effective-address correction for the X read, X write and Y address
 * units: circular buffers in X and Y, bit-reversed X writes.
 * Assumes decode presents pointer, offset, mode and unit each cycle; the
 * corrected address and pointer writeback are registered one cycle later.
 */
// Behaviour
// - X circular on when select not 15, enable
// - Y circular on when select not 15, enable
// - Four 16-bit boundary registers, up to 32K
// - Y circular addresses keep bit zero clear
// - Wrap past either boundary, overshoot corrected
// - Write back only for pre/post modify
// - One X and one Y buffer, any pointer but 15
// - Power-of-two buffers checked both ways
// - Bit reverse only in X write unit
// - Modifier reversed, addresses in normal order
// - Reverse needs select, enable, pre/post increment
// - Reverse control: enable bit15, pivot 14:0
// - Byte or other modes give plain addresses
// - Add pivot, ignore offset, clear bit zero
// - Pivot scaled to byte addresses
// - Reverse beats circular in X write only
// - Registers 10,11 use Y unit for dual reads
`timescale 1ns/1ps
`default_nettype none
`include "modulo_addr_defines.vh"

module modulo_bitrev_address_gen (
   input  wire        mclk,
   input  wire        reset,
   // Wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [5:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Request from decode
   input  wire        ea_req,
   input  wire [1:0]  ea_unit,
   input  wire [3:0]  ea_ptr_sel,
   input  wire [15:0] ea_ptr,
   input  wire [15:0] ea_offset,
   input  wire [2:0]  ea_mode,
   input  wire        ea_byte,
   input  wire        ea_dual,
   // Result
   output reg         ea_valid,
   output reg  [15:0] ea_addr,
   output reg         wb_ptr_en,
   output reg  [3:0]  wb_ptr_sel,
   output reg  [15:0] wb_ptr_val
);

   // Unit codes: 0 X read, 1 X write, 2 Y
   localparam [1:0] U_XR = 2'h0;
   localparam [1:0] U_XW = 2'h1;
   localparam [1:0] U_Y  = 2'h2;

   // ==========================================================
   // Registers
   reg [15:0] circ_ctrl_q;
   reg [15:0] x_start_q;
   reg [15:0] x_end_q;
   reg [15:0] y_start_q;
   reg [15:0] y_end_q;
   reg [15:0] rev_ctrl_q;
   reg [1:0]  last_kind_q;

   wire       wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire       wb_wr  = wb_hit & wb_we_i & wb_sel_i[0] & wb_sel_i[1];

   // Bus writes; one-cycle ack, low lanes carry 16-bit data
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         circ_ctrl_q <= `CIRC_CTRL_RST;
         x_start_q   <= `BOUND_RST;
         x_end_q     <= `BOUND_RST;
         y_start_q   <= `BOUND_RST;
         y_end_q     <= `BOUND_RST;
         rev_ctrl_q  <= `REV_CTRL_RST;
         wb_ack_o    <= 1'b0;
      end else begin
         wb_ack_o <= wb_hit;
         if (wb_wr) begin
            case (wb_adr_i)
               `OFS_CIRC_CTRL: circ_ctrl_q <= wb_dat_i[15:0];
               `OFS_X_START:   x_start_q   <= wb_dat_i[15:0];
               `OFS_X_END:     x_end_q     <= wb_dat_i[15:0];
               `OFS_Y_START:   y_start_q   <= wb_dat_i[15:0];
               `OFS_Y_END:     y_end_q     <= wb_dat_i[15:0];
               `OFS_REV_CTRL:  rev_ctrl_q  <= wb_dat_i[15:0];
               default: ;
            endcase
         end
      end
   end

   // Read data; unmapped reads return zero and still ack
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_hit) begin
         case (wb_adr_i)
            `OFS_CIRC_CTRL: wb_dat_o <= {16'h0000, circ_ctrl_q};
            `OFS_X_START:   wb_dat_o <= {16'h0000, x_start_q};
            `OFS_X_END:     wb_dat_o <= {16'h0000, x_end_q};
            `OFS_Y_START:   wb_dat_o <= {16'h0000, y_start_q};
            `OFS_Y_END:     wb_dat_o <= {16'h0000, y_end_q};
            `OFS_REV_CTRL:  wb_dat_o <= {16'h0000, rev_ctrl_q};
            `OFS_STATUS:    wb_dat_o <= {30'h0000_0000, last_kind_q};
            default:        wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Mode decode
   wire [3:0] x_sel = circ_ctrl_q[`XSEL_LSB+3:`XSEL_LSB];
   wire [3:0] y_sel = circ_ctrl_q[`YSEL_LSB+3:`YSEL_LSB];
   wire [3:0] r_sel = circ_ctrl_q[`RSEL_LSB+3:`RSEL_LSB];

   wire x_circ_on = (x_sel != `SEL_NONE) & circ_ctrl_q[`XEN_BIT];
   wire y_circ_on = (y_sel != `SEL_NONE) & circ_ctrl_q[`YEN_BIT];

   // Dual-operand reads force pointers 8,9 to X and 10,11 to Y
   wire [1:0] unit = ea_dual ? (ea_ptr_sel[1] ? U_Y : U_XR) : ea_unit;

   wire is_pre  = (ea_mode == `AM_PRE_INC)  | (ea_mode == `AM_PRE_DEC);
   wire is_post = (ea_mode == `AM_POST_INC) | (ea_mode == `AM_POST_DEC);
   wire is_inc  = (ea_mode == `AM_PRE_INC)  | (ea_mode == `AM_POST_INC);
   wire is_dec  = (ea_mode == `AM_PRE_DEC)  | (ea_mode == `AM_POST_DEC);

   // Stack pointer code equals the disable code, so it is never a target
   wire rev_act = (unit == U_XW) & (r_sel != `SEL_NONE)
                  & rev_ctrl_q[`REN_BIT] & is_inc & ~ea_byte
                  & (ea_ptr_sel == r_sel);

   // Any selected pointer may be circular; one buffer per space
   wire circ_act = (unit == U_Y) ? (y_circ_on & (ea_ptr_sel == y_sel))
                                 : (x_circ_on & (ea_ptr_sel == x_sel)
                                    & ~rev_act);

   wire [15:0] lo = (unit == U_Y) ? y_start_q : x_start_q;
   wire [15:0] hi = (unit == U_Y) ? y_end_q   : x_end_q;

   // ==========================================================
   // Circular correction
   wire [15:0] span  = hi - lo + 16'h0001;         // Bytes in buffer
   wire        pow2  = ((span & (span - 16'h0001)) == 16'h0000);
   wire [15:0] mod_ptr = ea_ptr + ea_offset;       // Offset is signed step
   wire [15:0] raw_ea  = is_post ? ea_ptr : mod_ptr;

   // Compare against the bounds, not equality, so overshoot still wraps
   function [15:0] wrap;
      input [15:0] a;
      input        up_chk;
      input        dn_chk;
      begin
         if (up_chk & (a > hi))
            wrap = a - span;
         else if (dn_chk & (a < lo))
            wrap = a + span;
         else
            wrap = a;
      end
   endfunction

   // Power-of-two buffers and offset mode check both bounds; others only their direction
   wire up_chk = is_inc | pow2 | (ea_mode == `AM_OFFSET);
   wire dn_chk = is_dec | pow2 | (ea_mode == `AM_OFFSET);

   wire [15:0] circ_ea  = wrap(raw_ea,  up_chk, dn_chk);
   wire [15:0] circ_ptr = wrap(mod_ptr, up_chk, dn_chk);

   // ==========================================================
   // Bit-reversed step: reverse-carry add of the scaled pivot
   wire [15:0] piv_bytes = {rev_ctrl_q[14:0], 1'b0};
   wire [15:0] ptr_r;
   wire [15:0] piv_r;
   wire [15:0] sum_r;
   wire [15:0] rev_ptr;
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_rev
         assign ptr_r[g]      = ea_ptr[15-g];
         assign piv_r[g]      = piv_bytes[15-g];
         assign rev_ptr[15-g] = sum_r[g];
      end
   endgenerate
   assign sum_r = ptr_r + piv_r;
   wire [15:0] rev_next = {rev_ptr[15:1], 1'b0};
   wire [15:0] rev_ea   = is_post ? {ea_ptr[15:1], 1'b0} : rev_next;

   // ==========================================================
   // Result selection
   reg [15:0] ea_d;
   reg [15:0] ptr_d;
   always @* begin
      if (rev_act) begin
         ea_d  = rev_ea;
         ptr_d = rev_next;
      end else if (circ_act) begin
         ea_d  = circ_ea;
         ptr_d = circ_ptr;
      end else begin
         ea_d  = raw_ea;
         ptr_d = mod_ptr;
      end
      if (circ_act & (unit == U_Y) & ~rev_act) begin
         ea_d[0]  = 1'b0;
         ptr_d[0] = 1'b0;
      end
   end

   // Output registers; writeback only for modify modes
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         ea_valid    <= 1'b0;
         ea_addr     <= 16'h0000;
         wb_ptr_en   <= 1'b0;
         wb_ptr_sel  <= 4'h0;
         wb_ptr_val  <= 16'h0000;
         last_kind_q <= 2'h0;
      end else begin
         ea_valid  <= ea_req;
         wb_ptr_en <= ea_req & (is_pre | is_post);
         if (ea_req) begin
            ea_addr     <= ea_d;
            wb_ptr_sel  <= ea_ptr_sel;
            wb_ptr_val  <= ptr_d;
            last_kind_q <= {rev_act, circ_act};
         end
      end
   end

endmodule // modulo_bitrev_address_gen
`default_nettype wire

// *** core/modulo_addr_defines.vh ***
/*
 * Offsets, field positions and reset values for the circular and
 * bit-reversed address correction block.
 * Assumes a 32-bit classic Wishbone slave, one register per aligned word.
 */
`ifndef MODULO_ADDR_DEFINES_VH
`define MODULO_ADDR_DEFINES_VH

// ==========================================================
// Register byte offsets
`define OFS_CIRC_CTRL   6'h00
`define OFS_X_START     6'h04
`define OFS_X_END       6'h08
`define OFS_Y_START     6'h0c
`define OFS_Y_END       6'h10
`define OFS_REV_CTRL    6'h14
`define OFS_STATUS      6'h18

// ==========================================================
// Control register fields
`define XSEL_LSB        0
`define YSEL_LSB        4
`define RSEL_LSB        8
`define YEN_BIT         14
`define XEN_BIT         15
`define REN_BIT         15
`define SEL_NONE        4'hf

// ==========================================================
// Reset values
`define CIRC_CTRL_RST   16'h0fff
`define REV_CTRL_RST    16'h0000
`define BOUND_RST       16'h0000

// ==========================================================
// Addressing mode codes from decode
`define AM_DIRECT       3'h0
`define AM_INDIRECT     3'h1
`define AM_POST_INC     3'h2
`define AM_POST_DEC     3'h3
`define AM_PRE_INC      3'h4
`define AM_PRE_DEC      3'h5
`define AM_OFFSET       3'h6

`endif

// *** sim/modulo_bitrev_address_gen_monitor.sv ***
/* Port checker for the address block.
   Assumes it is bound to the design top. */
`timescale 1ns/1ps
`default_nettype none
module modulo_bitrev_address_gen_monitor (
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        ea_req,
   input wire logic [1:0]  ea_unit,
   input wire logic [2:0]  ea_mode,
   input wire logic [3:0]  ea_ptr_sel,
   input wire logic [15:0] ea_ptr,
   input wire logic        ea_valid,
   input wire logic [15:0] ea_addr,
   input wire logic        wb_ptr_en,
   input wire logic [3:0]  wb_ptr_sel
);
   // ==========
   // Timing relations, one clock domain
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   wire take   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire modify = ea_req & (ea_mode > 3'h1) & (ea_mode < 3'h6);
   ack_one_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_next_a: assert property (take |=> wb_ack_o) else $error("ack late");
   ack_cause_a: assert property (wb_ack_o |-> $past(take)) else $error("ack unasked");
   valid_next_a: assert property (ea_req |=> ea_valid) else $error("valid late");
   valid_cause_a: assert property (ea_valid |-> $past(ea_req)) else $error("valid unasked");
   keep_ptr_a: assert property (ea_req && !modify |=> !wb_ptr_en)
      else $error("pointer written");
   write_back_a: assert property (
      modify |=> wb_ptr_en && wb_ptr_sel == $past(ea_ptr_sel)) else $error("pointer lost");
   plain_ea_a: assert property (
      ea_req && ea_mode == 3'h1 && ea_unit == 2'h1 |=> ea_addr == $past(ea_ptr))
      else $error("address changed");
   cover property (modify ##1 wb_ptr_en);
   cover property (take ##1 wb_ack_o);
   cover property (ea_req && ea_mode == 3'h6);
endmodule // modulo_bitrev_address_gen_monitor
bind modulo_bitrev_address_gen modulo_bitrev_address_gen_monitor
   modulo_bitrev_address_gen_monitor_inst (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .ea_req, .ea_unit, .ea_mode, .ea_ptr_sel, .ea_ptr, .ea_valid, .ea_addr, .wb_ptr_en,
   .wb_ptr_sel);
`default_nettype wire

// *** sim/decode_model.sv ***
/* Decode and working-register model facing the address block.
   Assumes the bench drives it through load and issue. */
`timescale 1ns/1ps
`default_nettype none
module decode_model (
   input  wire logic        mclk,
   input  wire logic [15:0] ea_addr,
   input  wire logic        wb_ptr_en,
   input  wire logic [3:0]  wb_ptr_sel,
   input  wire logic [15:0] wb_ptr_val,
   output var  logic        ea_req,
   output var  logic [1:0]  ea_unit,
   output var  logic [3:0]  ea_ptr_sel,
   output var  logic [15:0] ea_ptr,
   output var  logic [15:0] ea_offset,
   output var  logic [2:0]  ea_mode,
   output var  logic        ea_byte,
   output var  logic        ea_dual
);
   logic [15:0] regs [0:15];
   logic [15:0] last_addr, last_ptr;
   // Corrected pointer returns to the register file
   always @(posedge mclk) if (wb_ptr_en) regs[wb_ptr_sel] <= wb_ptr_val;
   initial {ea_req, ea_unit, ea_ptr_sel, ea_ptr, ea_offset, ea_mode, ea_byte, ea_dual} = '0;
   task automatic load(input logic [3:0] s, input logic [15:0] v);
      @(negedge mclk) regs[s] = v;
   endtask
   // One request; pointer scrambled once released so stale data cannot pass
   task automatic issue(input logic [1:0] u, input logic [3:0] s, input logic [2:0] m,
      input logic [15:0] o, input logic b, input logic d);
      @(posedge mclk);
      {ea_req, ea_unit, ea_ptr_sel, ea_mode, ea_offset, ea_byte, ea_dual} <= {1'b1, u, s, m, o, b, d};
      ea_ptr <= regs[s];
      @(posedge mclk);
      ea_req <= 1'b0;
      ea_ptr <= ~ea_ptr;
      @(posedge mclk);
      last_addr = ea_addr;
      last_ptr = wb_ptr_val;
   endtask
endmodule // decode_model
`default_nettype wire

// *** sim/modulo_bitrev_address_gen_tb_top.sv ***
/* Self-checking bench for the address block.
   Assumes the decode model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module modulo_bitrev_address_gen_tb_top;
   logic        mclk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ea_req, ea_byte, ea_dual;
   logic        ea_valid, wb_ptr_en;
   logic [1:0]  ea_unit;
   logic [2:0]  ea_mode;
   logic [3:0]  ea_ptr_sel, wb_ptr_sel;
   logic [5:0]  wb_adr_i;
   logic [15:0] ea_ptr, ea_offset, ea_addr, wb_ptr_val, q;
   logic [31:0] wb_dat_i, wb_dat_o;
   int          bad_count, samples_checked, cycles;
   modulo_bitrev_address_gen modulo_bitrev_address_gen_inst (.mclk, .reset, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .ea_req, .ea_unit, .ea_ptr_sel, .ea_ptr, .ea_offset, .ea_mode, .ea_byte, .ea_dual,
      .ea_valid, .ea_addr, .wb_ptr_en, .wb_ptr_sel, .wb_ptr_val);
   decode_model decode_model_inst (.mclk, .ea_addr, .wb_ptr_en, .wb_ptr_sel, .wb_ptr_val,
      .ea_req, .ea_unit, .ea_ptr_sel, .ea_ptr, .ea_offset, .ea_mode, .ea_byte, .ea_dual);
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Hang guard; the run needs well under a thousand cycles
   always @(posedge mclk) if (++cycles == 3000) begin
      bad_count++;
      print_verdict();
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [5:0] a, input logic [15:0] d);
      @(posedge mclk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, 16'h0000, d};
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o[15:0];
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask
   // Registers 8 to 11 go as dual-operand reads
   task automatic op(input logic [1:0] u, input logic [3:0] s, input logic [15:0] p,
      input logic [2:0] m, input logic [15:0] o, input logic b, input logic [15:0] ea, wp);
      decode_model_inst.load(s, p);
      decode_model_inst.issue(u, s, m, o, b, s[3] & ~s[2]);
      check(decode_model_inst.last_addr, ea);
      if (m inside {[2:5]}) check(decode_model_inst.last_ptr, wp);
   endtask
   // Circular X buffer of sixteen bytes; off once its select is 15, the stack pointer code
   task automatic circ_x_scen;
      wb(0, 6'h00, 0);
      check(q, 16'h0fff);
      wb(1, 6'h04, 16'h1000);
      wb(1, 6'h08, 16'h100f);
      wb(1, 6'h00, 16'h8ff2);
      op(0, 2, 16'h100e, 2, 2, 0, 16'h100e, 16'h1000);
      op(1, 2, 16'h100c, 4, 4, 0, 16'h1000, 16'h1000);
      op(0, 2, 16'h1000, 3, 16'hfffe, 0, 16'h1000, 16'h100e);
      op(0, 2, 16'h100e, 6, 4, 0, 16'h1002, 0);
      wb(1, 6'h00, 16'h8fff);
      op(0, 2, 16'h100e, 2, 2, 0, 16'h100e, 16'h1010);
      op(1, 5, 16'h1234, 1, 0, 0, 16'h1234, 0);
   endtask
   task automatic circ_y_scen;
      wb(1, 6'h0c, 16'h2000);
      wb(1, 6'h10, 16'h2007);
      wb(0, 6'h10, 0);
      check(q, 16'h2007);
      wb(1, 6'h00, 16'h4faf);
      op(0, 10, 16'h2006, 2, 2, 0, 16'h2006, 16'h2000);
      op(0, 8, 16'h2006, 2, 2, 0, 16'h2006, 16'h2008);
      op(2, 10, 16'h2003, 1, 0, 0, 16'h2002, 0);
   endtask
   // Reversed buffer starts at zero, aligned to its size
   task automatic rev_scen;
      logic [15:0] seq [0:4];
      seq = '{16'h0000, 16'h0008, 16'h0004, 16'h000c, 16'h0002};
      wb(1, 6'h14, 16'h8004);
      wb(1, 6'h00, 16'h03ff);
      wb(0, 6'h14, 0);
      check(q, 16'h8004);
      for (int i = 0; i < 4; i++) op(1, 3, seq[i], 2, 6, 0, seq[i], seq[i+1]);
      op(1, 3, 16'h0008, 2, 1, 1, 16'h0008, 16'h0009);
      op(0, 3, 16'h0008, 2, 2, 0, 16'h0008, 16'h000a);
      wb(1, 6'h04, 16'h0000);
      wb(1, 6'h08, 16'h0007);
      wb(1, 6'h00, 16'h83f3);
      op(1, 3, 16'h0004, 2, 2, 0, 16'h0004, 16'h000c);
      op(0, 3, 16'h0006, 2, 2, 0, 16'h0006, 16'h0000);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      {reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {1'b1, 41'h0};
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      circ_x_scen();
      circ_y_scen();
      rev_scen();
      print_verdict();
   end
endmodule // modulo_bitrev_address_gen_tb_top
`default_nettype wire
